// ===== rtl/servo_status_and_encoder_out.sv
// Functional notes
// - ready after servo-on and drive operable
// - fault-free drops on power loss or trip
// - fault-free rises within 1.5 s
// - remote alarm bit inverts fault-free
// - homing done on successful home return
// - abs mode: servo-off, stop, reset, alarm occurrence
// - either stroke end off clears homing done
// - new homing needed after invalidating events
// - off while homing; station param change clears
// - valid homing done follows ready
// - manual pulse inputs ignored in indexer mode
// - quadrature pulses per rev from parameter
// - ccw: b lags a quarter cycle
// - one zero pulse per revolution
// - zero output active low at zero point
// - zero pulse at least 400 us wide
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module servo_status_and_encoder_out #(
  parameter longint alm_cyc = servo_out_pkg::alm_cyc,
  parameter longint zpw_cyc = servo_out_pkg::zpw_cyc
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // drive state
  input wire logic servo_on_cmd_i,
  input wire logic drive_operable_i,
  input wire logic power_ok_i,
  input wire logic base_shutoff_i,
  input wire logic alarm_i,
  input wire logic abs_position_erase_alarm_i,
  input wire logic abs_counter_warning_i,
  // pins
  input wire logic forced_stop_in_i,
  input wire logic fwd_stroke_end_in_i,
  input wire logic rev_stroke_end_in_i,
  input wire logic manual_pulse_fwd_in_i,
  input wire logic manual_pulse_rev_in_i,
  // motor position
  input wire logic motor_step_i,
  input wire logic motor_ccw_i,
  // status outputs
  output logic ready_out_o,
  output logic fault_free_out_o,
  output logic remote_alarm_bit_o,
  output logic homing_done_out_o,
  output logic remote_homing_done_bit_o,
  output logic manual_fwd_o,
  output logic manual_rev_o,
  output logic quad_a_out_o,
  output logic quad_b_out_o,
  output logic zero_point_out_n_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
    end else begin
      meta_r <= {forced_stop_in_i, fwd_stroke_end_in_i, rev_stroke_end_in_i,
                 manual_pulse_fwd_in_i, manual_pulse_rev_in_i};
      sync_r <= meta_r;
    end
  end
  wire stop_closed = sync_r[4];
  wire fwd_on = sync_r[3];
  wire rev_on = sync_r[2];

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  localparam int irq_w_l = servo_out_pkg::irq_w;
  logic [7:0] ctrl_r;
  logic [irq_w_l-1:0] irq_stat_r;
  logic [irq_w_l-1:0] irq_mask_r;
  logic [15:0] pulses_r;
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire rd = acc && !pwrite_i;
  wire hit_ctrl = paddr_i == servo_out_pkg::ctrl_addr;
  wire hit_stat = paddr_i == servo_out_pkg::status_addr;
  wire hit_irq = paddr_i == servo_out_pkg::irq_stat_addr;
  wire hit_mask = paddr_i == servo_out_pkg::irq_mask_addr;
  wire hit_pul = paddr_i == servo_out_pkg::pulses_addr;
  wire hit_pos = paddr_i == servo_out_pkg::pos_addr;
  wire hit_any = hit_ctrl | hit_stat | hit_irq | hit_mask | hit_pul | hit_pos;
  // self-clearing strobes from control writes
  wire [7:0] wctl = (wr && hit_ctrl) ? pwdata_i[7:0] : 8'h00;
  wire home_req = wctl[servo_out_pkg::ctrl_home_req];
  wire home_ok = wctl[servo_out_pkg::ctrl_home_ok];
  wire gear_chg = wctl[servo_out_pkg::ctrl_gear_chg];
  wire stn_chg = wctl[servo_out_pkg::ctrl_stn_dir_chg];
  wire rem_rst = wctl[servo_out_pkg::ctrl_remote_reset];
  wire abs_en = ctrl_r[servo_out_pkg::ctrl_abs_en];
  wire indexer = ctrl_r[servo_out_pkg::ctrl_indexer];
  wire abs_en_rise = wr && hit_ctrl && !abs_en &&
                     pwdata_i[servo_out_pkg::ctrl_abs_en];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= 8'h00;
      irq_mask_r <= '0;
      pulses_r <= servo_out_pkg::pulses_rst;
    end else if (wr) begin
      if (hit_ctrl) ctrl_r <= {6'h00, pwdata_i[1:0]};
      if (hit_mask) irq_mask_r <= pwdata_i[irq_w_l-1:0];
      if (hit_pul && pwdata_i[15:0] != 16'h0000) pulses_r <= pwdata_i[15:0];
    end
  end

  // ---------------------------------------------------------------
  // ready and fault-free
  // ---------------------------------------------------------------
  logic ready_r;
  logic fault_free_r;
  logic remote_alarm_r;
  logic [31:0] pon_cnt_r;
  wire pon_done = pon_cnt_r >= 32'(alm_cyc);
  wire any_alarm = alarm_i | abs_position_erase_alarm_i | base_shutoff_i;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pon_cnt_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      fault_free_r <= 1'b0;
      remote_alarm_r <= 1'b1;
    end else begin
      if (!power_ok_i) pon_cnt_r <= 32'h0000_0000;
      else if (!pon_done) pon_cnt_r <= pon_cnt_r + 32'h0000_0001;
      ready_r <= servo_on_cmd_i && drive_operable_i && fault_free_r;
      fault_free_r <= power_ok_i && !any_alarm && pon_done;
      // own flop so the remote bit leaves the block straight from a register
      remote_alarm_r <= !(power_ok_i && !any_alarm && pon_done);
    end
  end

  // ---------------------------------------------------------------
  // home return state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    hs_none = 2'b00,
    hs_homing = 2'b01,
    hs_valid = 2'b10
  } home_state_t;
  home_state_t hs_r;
  home_state_t hs_nxt;
  wire stroke_off = !fwd_on || !rev_on;
  wire abs_lost = abs_en && (!servo_on_cmd_i || !stop_closed || rem_rst ||
                             any_alarm);
  // these events demand a fresh home return before reporting again
  wire invalidate = abs_position_erase_alarm_i | abs_counter_warning_i |
                    gear_chg | abs_en_rise | stn_chg;
  always_comb begin
    hs_nxt = hs_r;
    unique case (hs_r)
      hs_none: if (home_req) hs_nxt = hs_homing;
      hs_homing: if (home_ok) hs_nxt = hs_valid;
      hs_valid: if (home_req) hs_nxt = hs_homing;
      default: hs_nxt = hs_none;
    endcase
    if (invalidate || abs_lost) hs_nxt = hs_none;
  end
  logic homing_done_r;
  wire homing_done_nxt = (hs_r == hs_valid) && !stroke_off &&
                         !abs_lost && ready_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hs_r <= hs_none;
      homing_done_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      homing_done_r <= homing_done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // manual pulse gating
  // ---------------------------------------------------------------
  logic man_fwd_r;
  logic man_rev_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      man_fwd_r <= 1'b0;
      man_rev_r <= 1'b0;
    end else begin
      man_fwd_r <= sync_r[1] && !indexer;
      man_rev_r <= sync_r[0] && !indexer;
    end
  end

  // ---------------------------------------------------------------
  // encoder emulation: one edge per output-count quarter step
  // ---------------------------------------------------------------
  logic [17:0] pos_r;
  logic step_r;
  logic dir_r;
  logic rev_evt_r;
  wire [17:0] edges_per_rev = {pulses_r, 2'b00};
  wire at_top = pos_r == edges_per_rev - 18'h0_0001;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pos_r <= 18'h0_0000;
      step_r <= 1'b0;
      dir_r <= 1'b0;
      rev_evt_r <= 1'b0;
    end else begin
      step_r <= motor_step_i;
      dir_r <= motor_ccw_i;
      rev_evt_r <= 1'b0;
      if (motor_step_i && motor_ccw_i) begin
        pos_r <= at_top ? 18'h0_0000 : pos_r + 18'h0_0001;
        rev_evt_r <= at_top;
      end else if (motor_step_i) begin
        pos_r <= (pos_r == 18'h0_0000) ? edges_per_rev - 18'h0_0001
                                       : pos_r - 18'h0_0001;
        rev_evt_r <= pos_r == 18'h0_0001;
      end
    end
  end
  quad_encoder_out u_quad (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .step_i(step_r),
    .dir_ccw_i(dir_r),
    .quad_a_o(quad_a_out_o),
    .quad_b_o(quad_b_out_o)
  );
  // pulse stretched to the minimum width; a crossing during it restarts it
  logic [31:0] zp_cnt_r;
  logic zp_n_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      zp_cnt_r <= 32'h0000_0000;
      zp_n_r <= 1'b1;
    end else if (rev_evt_r) begin
      zp_cnt_r <= 32'(zpw_cyc);
      zp_n_r <= 1'b0;
    end else if (zp_cnt_r != 32'h0000_0000) begin
      zp_cnt_r <= zp_cnt_r - 32'h0000_0001;
      zp_n_r <= zp_cnt_r == 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // interrupts and read data
  // ---------------------------------------------------------------
  wire rd_irq = rd && hit_irq;
  wire [irq_w_l-1:0] irq_evt = {rev_evt_r,
                                homing_done_r && !homing_done_nxt,
                                homing_done_nxt && !homing_done_r,
                                fault_free_r && !(power_ok_i && !any_alarm)};
  wire [31:0] status_word = {28'h000_0000, (hs_r == hs_homing),
                             homing_done_r, fault_free_r, ready_r};
  wire [31:0] rdata =
    hit_ctrl ? {24'h00_0000, ctrl_r} :
    hit_stat ? status_word :
    hit_irq ? {28'h000_0000, irq_stat_r} :
    hit_mask ? {28'h000_0000, irq_mask_r} :
    hit_pul ? {16'h0000, pulses_r} :
    hit_pos ? {14'h0000, pos_r} : servo_out_pkg::zero_data;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      prdata_r <= servo_out_pkg::zero_data;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      // only bits already handed out by the read are cleared, so an
      // event landing at the setup edge is not lost
      irq_stat_r <= (irq_stat_r & ~(rd_irq ? prdata_r[irq_w_l-1:0] : '0)) |
                    irq_evt;
      prdata_r <= (psel_i && !penable_i) ? rdata : prdata_r;
      pslverr_r <= psel_i && !penable_i && !hit_any;
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_r;
  assign ready_out_o = ready_r;
  assign fault_free_out_o = fault_free_r;
  assign remote_alarm_bit_o = remote_alarm_r;
  assign homing_done_out_o = homing_done_r;
  assign remote_homing_done_bit_o = homing_done_r;
  assign manual_fwd_o = man_fwd_r;
  assign manual_rev_o = man_rev_r;
  assign zero_point_out_n_o = zp_n_r;
  assign irq_o = irq_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_ready;
    @(posedge clock_i) disable iff (rst_i)
      ready_r |-> $past(servo_on_cmd_i) && $past(drive_operable_i);
  endproperty
  a_ready: assert property (p_ready) else $error("ready without servo-on");
  property p_ff_drop;
    @(posedge clock_i) disable iff (rst_i)
      !power_ok_i |=> !fault_free_r;
  endproperty
  a_ff_drop: assert property (p_ff_drop) else $error("fault-free held");
  property p_remote_alm;
    @(posedge clock_i) disable iff (rst_i)
      remote_alarm_bit_o != fault_free_out_o;
  endproperty
  a_remote_alm: assert property (p_remote_alm) else $error("alarm polarity");
  property p_stroke;
    @(posedge clock_i) disable iff (rst_i)
      stroke_off |=> !homing_done_r;
  endproperty
  a_stroke: assert property (p_stroke) else $error("stroke end ignored");
  property p_follow;
    @(posedge clock_i) disable iff (rst_i)
      homing_done_r |-> ready_r || $past(ready_r);
  endproperty
  a_follow: assert property (p_follow) else $error("homing done w/o ready");
  property p_homing_off;
    @(posedge clock_i) disable iff (rst_i)
      hs_r == hs_homing |=> !homing_done_r;
  endproperty
  a_homing_off: assert property (p_homing_off) else $error("done while homing");
  property p_indexer;
    @(posedge clock_i) disable iff (rst_i)
      indexer && $past(indexer) |-> !man_fwd_r && !man_rev_r;
  endproperty
  a_indexer: assert property (p_indexer) else $error("manual pulse passed");
  property p_zp;
    @(posedge clock_i) disable iff (rst_i)
      rev_evt_r |=> !zp_n_r [*8];
  endproperty
  a_zp: assert property (p_zp) else $error("zero pulse too short");
endmodule

// ===== rtl/servo_out_pkg.sv
package servo_out_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] irq_stat_addr = 12'h008;
  localparam logic [11:0] irq_mask_addr = 12'h00c;
  localparam logic [11:0] pulses_addr = 12'h010;
  localparam logic [11:0] pos_addr = 12'h014;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int ctrl_abs_en = 0;
  localparam int ctrl_indexer = 1;
  localparam int ctrl_home_req = 2;
  localparam int ctrl_home_ok = 3;
  localparam int ctrl_gear_chg = 4;
  localparam int ctrl_stn_dir_chg = 5;
  localparam int ctrl_remote_reset = 6;
  localparam int ctrl_erase_evt = 7;
  // ---------------------------------------------------------------
  // status / irq fields
  // ---------------------------------------------------------------
  localparam int st_ready = 0;
  localparam int st_fault_free = 1;
  localparam int st_homing_done = 2;
  localparam int st_homing = 3;
  localparam int irq_w = 4;
  localparam int irq_alarm = 0;
  localparam int irq_home_done = 1;
  localparam int irq_home_lost = 2;
  localparam int irq_rev = 3;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] pulses_rst = 16'h1000;
  localparam logic [31:0] zero_data = 32'h0000_0000;
  localparam longint clk_hz = 250000000;
  localparam longint alm_ms = 1500;
  localparam longint alm_cyc = (alm_ms * clk_hz) / 1000 - 1;
  localparam longint zpw_us = 400;
  localparam longint zpw_cyc = (zpw_us * clk_hz) / 1000000;
endpackage

// ===== rtl/quad_encoder_out.sv
`timescale 1ns/1ps
module quad_encoder_out (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // motion
  input wire logic step_i,
  input wire logic dir_ccw_i,
  // outputs
  output logic quad_a_o,
  output logic quad_b_o
);
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  // gray step: ccw goes 00-10-11-01 on (a,b), so b lags a
  assign phase_nxt = dir_ccw_i ? {~phase_r[0], phase_r[1]}
                               : {phase_r[0], ~phase_r[1]};
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= 2'h0;
    end else if (step_i) begin
      phase_r <= phase_nxt;
    end
  end
  assign quad_a_o = phase_r[1];
  assign quad_b_o = phase_r[0];
endmodule

// ===== testbench/host_encoder_model.sv
`timescale 1ns/1ps
module host_encoder_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // encoder lines from the drive
  input wire logic quad_a_i,
  input wire logic quad_b_i,
  input wire logic zero_n_i,
  // decoded results
  output logic signed [31:0] count_o,
  output logic [31:0] z_count_o,
  output logic [31:0] z_width_o,
  output logic [31:0] bad_o
);
  // ---------------------------------------------------------------
  // quadrature decode, gray index 00,10,11,01 counts up
  // ---------------------------------------------------------------
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic [1:0] diff;
  logic [31:0] low_r;
  assign idx_nxt = {quad_b_i, quad_a_i ^ quad_b_i};
  assign diff = idx_nxt - idx_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      idx_r <= 2'h0;
      count_o <= 32'sh0000_0000;
      z_count_o <= 32'h0000_0000;
      z_width_o <= 32'h0000_0000;
      bad_o <= 32'h0000_0000;
      low_r <= 32'h0000_0000;
    end else begin
      idx_r <= idx_nxt;
      // a double jump cannot be told apart, so it is only counted
      if (diff == 2'h1) begin
        count_o <= count_o + 1;
      end else if (diff == 2'h3) begin
        count_o <= count_o - 1;
      end else if (diff == 2'h2) begin
        bad_o <= bad_o + 1;
      end
      if (!zero_n_i) begin
        low_r <= low_r + 1;
      end else if (low_r != 32'h0000_0000) begin
        z_count_o <= z_count_o + 1;
        z_width_o <= low_r;
        low_r <= 32'h0000_0000;
      end
    end
  end
endmodule

// ===== testbench/servo_status_and_encoder_out_tb_top.sv
`timescale 1ns/1ps
module servo_status_and_encoder_out_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int ppr = 4;
  logic clock_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, er;
  logic servo_on_cmd_i, drive_operable_i, power_ok_i, base_shutoff_i;
  logic alarm_i, abs_position_erase_alarm_i, abs_counter_warning_i;
  logic forced_stop_in_i, fwd_stroke_end_in_i, rev_stroke_end_in_i;
  logic manual_pulse_fwd_in_i, manual_pulse_rev_in_i;
  logic motor_step_i, motor_ccw_i;
  logic ready_out_o, fault_free_out_o, remote_alarm_bit_o;
  logic homing_done_out_o, remote_homing_done_bit_o;
  logic manual_fwd_o, manual_rev_o, quad_a_out_o, quad_b_out_o;
  logic zero_point_out_n_o, irq_o;
  logic signed [31:0] cnt;
  logic [31:0] zc, zw, bad;
  logic [31:0] b;
  int failures, total_checks, n, seed, exp_pos, exp_z;
  servo_status_and_encoder_out #(.alm_cyc(20), .zpw_cyc(10)) i_dut (.*);
  host_encoder_model i_host (.clock_i(clock_i), .rst_i(rst_i),
    .quad_a_i(quad_a_out_o), .quad_b_i(quad_b_out_o),
    .zero_n_i(zero_point_out_n_o), .count_o(cnt), .z_count_o(zc),
    .z_width_o(zw), .bad_o(bad));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task test_done();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  // one apb transfer; waits on pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      test_done();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task home();
    apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0005);
    tick(3);
    chk("homing_busy", 1'b0, homing_done_out_o);
    apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0009);
    tick(3);
    chk("homed", 1'b1, homing_done_out_o);
    chk("homed_rmt", 1'b1, remote_homing_done_bit_o);
  endtask
  // steps are spaced well apart, as a slow creep would be
  task step(input logic ccw);
    motor_ccw_i <= ccw;
    motor_step_i <= 1'b1;
    @(posedge clock_i);
    motor_step_i <= 1'b0;
    tick(15);
    exp_pos = exp_pos + (ccw ? 1 : -1);
    if (exp_pos % (4 * ppr) == 0) exp_z++;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    #400000;
    failures++;
    test_done();
  end
  initial begin
    seed = 62332;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {servo_on_cmd_i, drive_operable_i, base_shutoff_i, alarm_i} = '0;
    {abs_position_erase_alarm_i, abs_counter_warning_i} = '0;
    {manual_pulse_fwd_in_i, manual_pulse_rev_in_i} = '0;
    {motor_step_i, motor_ccw_i} = '0;
    {power_ok_i, forced_stop_in_i} = 2'h3;
    {fwd_stroke_end_in_i, rev_stroke_end_in_i} = 2'h3;
    rst_i = 1'b1;
    exp_pos = 0;
    exp_z = 0;
    tick(16);
    rst_i <= 1'b0;
    n = 0;
    while (fault_free_out_o !== 1'b1 && n < 60) begin
      @(posedge clock_i);
      n++;
    end
    chk("zero_idle", 1'b1, zero_point_out_n_o);
    chk("ff_delay", 1'b1, n >= 18 && n <= 24);
    chk("rmt_alarm", 1'b0, remote_alarm_bit_o);
    apb(1'b0, servo_out_pkg::pulses_addr, 32'h0000_0000);
    chk("pulses_rst", 32'h0000_1000, rd);
    apb(1'b0, 12'h0ff, 32'h0000_0000);
    chk("unmapped_err", 1'b1, er);
    chk("unmapped_rd", 32'h0000_0000, rd);
    servo_on_cmd_i <= 1'b1;
    tick(3);
    chk("rdy_inop", 1'b0, ready_out_o);
    drive_operable_i <= 1'b1;
    tick(3);
    chk("rdy", 1'b1, ready_out_o);
    chk("never_homed", 1'b0, homing_done_out_o);
    apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0001);
    home();
    chk("irq_masked", 1'b0, irq_o);
    apb(1'b1, servo_out_pkg::irq_mask_addr, 32'h0000_0002);
    tick(2);
    chk("irq_on", 1'b1, irq_o);
    apb(1'b0, servo_out_pkg::irq_stat_addr, 32'h0000_0000);
    chk("irq_bit", 1'b1, rd[servo_out_pkg::irq_home_done]);
    tick(3);
    chk("irq_off", 1'b0, irq_o);
    apb(1'b0, servo_out_pkg::status_addr, 32'h0000_0000);
    chk("status", 32'h0000_0007, rd);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) fwd_stroke_end_in_i <= 1'b0;
      else rev_stroke_end_in_i <= 1'b0;
      tick(6);
      chk("stroke_off", 1'b0, homing_done_out_o);
      {fwd_stroke_end_in_i, rev_stroke_end_in_i} <= 2'h3;
      tick(6);
      chk("stroke_on", 1'b1, homing_done_out_o);
    end
    for (int k = 0; k < 8; k++) begin
      case (k)
        0: servo_on_cmd_i <= 1'b0;
        1: forced_stop_in_i <= 1'b0;
        2: apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0041);
        3: apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0011);
        4: apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0021);
        5: abs_position_erase_alarm_i <= 1'b1;
        6: abs_counter_warning_i <= 1'b1;
        default: begin
          apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0000);
          apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0001);
        end
      endcase
      tick(6);
      chk("lost", 1'b0, homing_done_out_o);
      {servo_on_cmd_i, forced_stop_in_i} <= 2'h3;
      {abs_position_erase_alarm_i, abs_counter_warning_i} <= 2'h0;
      tick(6);
      chk("stay_lost", 1'b0, homing_done_out_o);
      chk("rdy_back", 1'b1, ready_out_o);
      home();
    end
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        b = $random(seed);
        manual_pulse_fwd_in_i <= b[0];
        manual_pulse_rev_in_i <= b[1];
        tick(5);
        chk("man_fwd", b[0] & (m == 0), manual_fwd_o);
        chk("man_rev", b[1] & (m == 0), manual_rev_o);
      end
      apb(1'b1, servo_out_pkg::ctrl_addr, 32'h0000_0003);
    end
    apb(1'b1, servo_out_pkg::pulses_addr, ppr);
    apb(1'b1, servo_out_pkg::pulses_addr, 32'h0000_0000);
    apb(1'b0, servo_out_pkg::pulses_addr, 32'h0000_0000);
    chk("pulses", ppr, rd);
    for (int d = 1; d >= 0; d--) begin
      repeat (8 * ppr) step(d[0]);
      tick(20);
      chk("quad_pos", exp_pos, cnt);
      chk("quad_skip", 32'h0000_0000, bad);
      chk("z_count", exp_z, zc);
      chk("z_width", 32'h0000_000a, zw);
    end
    base_shutoff_i <= 1'b1;
    tick(4);
    chk("ff_trip", 1'b0, fault_free_out_o);
    chk("rmt_trip", 1'b1, remote_alarm_bit_o);
    chk("rdy_trip", 1'b0, ready_out_o);
    chk("home_trip", 1'b0, homing_done_out_o);
    test_done();
  end
endmodule
